// >>> verilog/frs_pkg.sv
package frs_pkg;

    typedef enum logic [1:0] {
        TERM_OK      = 2'b00,
        TERM_FAIL    = 2'b01,
        TERM_INVALID = 2'b10,
        TERM_POLL    = 2'b11
    } frs_term_type;

    typedef enum logic [3:0] {
        CMD_NONE       = 4'b0000,
        CMD_READ       = 4'b0001,
        CMD_READ_DEL   = 4'b0010,
        CMD_READ_ID    = 4'b0011,
        CMD_READ_TRACK = 4'b0100,
        CMD_WRITE      = 4'b0101,
        CMD_WRITE_DEL  = 4'b0110,
        CMD_FORMAT     = 4'b0111,
        CMD_RECAL      = 4'b1000,
        CMD_SEEK       = 4'b1001,
        CMD_REL_SEEK   = 4'b1010
    } frs_cmd_type;

    typedef enum logic [1:0] {
        RS_RUN = 2'b00,
        RS_DOR = 2'b01,
        RS_DSR = 2'b10
    } frs_rst_type;

    typedef enum logic [1:0] {
        SEL_ST0 = 2'b00,
        SEL_ST1 = 2'b01,
        SEL_ST2 = 2'b10,
        SEL_ST3 = 2'b11
    } frs_sel_type;

    localparam logic [6:0] RECAL_LIMIT = 7'h50;
    localparam logic [6:0] STEP_ONE    = 7'h01;
    localparam logic [1:0] IDX_LIMIT   = 2'h2;
    localparam logic [1:0] IDX_ONE     = 2'h1;
    localparam logic [7:0] BAD_TRACK   = 8'hFF;
    localparam logic [2:0] DSR_HOLD    = 3'h4;
    localparam logic [2:0] DSR_ONE     = 3'h1;
    localparam logic       BIT_ZERO    = 1'h0;
    localparam logic       BIT_ONE     = 1'h1;

    typedef struct packed {
        logic [1:0] termination_code;
        logic       positioning_done;
        logic       drive_fault_flag;
        logic       unused3;
        logic       side_status;
        logic [1:0] drive_number;
    } frs_st0_type;

    typedef struct packed {
        logic end_of_track;
        logic unused6;
        logic crc_fault;
        logic service_late;
        logic unused3;
        logic sector_absent;
        logic write_blocked;
        logic id_sync_missing;
    } frs_st1_type;

    typedef struct packed {
        logic unused7;
        logic control_mark;
        logic data_crc_fault;
        logic wrong_cylinder;
        logic unused3;
        logic unused2;
        logic bad_cylinder;
        logic data_sync_missing;
    } frs_st2_type;

    typedef struct packed {
        logic       unused7;
        logic       write_protect;
        logic       one5;
        logic       track_zero_status;
        logic       one3;
        logic       side_status;
        logic [1:0] drive_number;
    } frs_st3_type;

    typedef struct packed {
        logic transfer_end_input;
        logic track_zero_input;
        logic write_protect_input;
        logic index_input;
        logic hw_reset;
    } frs_pins_type;

    typedef struct packed {
        logic         cmd_start;
        logic         term_valid;
        frs_term_type term_code;
        logic         pos_end;
        logic         step;
        logic         rel_under;
        logic         sec_over;
        logic         xfer_done;
        logic         id_crc;
        logic         data_crc;
        logic         late;
        logic         not_found;
        logic         id_fail;
        logic         seq_fail;
        logic         id_search;
        logic         id_found;
        logic         mark_seen;
        logic         mark_deleted;
        logic         mark_missing;
        logic         id_valid;
        logic [7:0]   id_track;
    } frs_ev_type;

    typedef struct packed {
        frs_rst_type  rst_state;
        logic         dor_rst;
        logic [2:0]   dsr_cnt;
        logic         exit;
        logic         pd;
        logic         poll_en;
        logic [7:0]   cfg;
        logic [7:0]   spec;
        frs_pins_type pins_meta;
        frs_pins_type pins;
        logic         idx_prev;
        logic [6:0]   step_cnt;
        logic [1:0]   idx_cnt;
        frs_st0_type  s0;
        frs_st1_type  s1;
        frs_st2_type  s2;
        logic [7:0]   rdata;
    } frs_state_type;

    localparam frs_state_type ST_RESET = '{
        default:   '0,
        rst_state: RS_DOR,
        dor_rst:   1'h1,
        poll_en:   1'h1
    };

endpackage

// >>> verilog/frs_result_status.sv
module frs_result_status (
    input  wire logic                 core_clk,
    input  wire logic                 srst,
    input  wire frs_pkg::frs_ev_type  ev,
    input  wire frs_pkg::frs_cmd_type cmd_class,
    input  wire logic [7:0]           cur_track,
    input  wire logic                 cur_head,
    input  wire logic [1:0]           cur_drive,
    input  wire frs_pkg::frs_pins_type pins_raw,
    input  wire logic                 dor_wr,
    input  wire logic                 dor_reset_n,
    input  wire logic                 dsr_wr,
    input  wire logic                 dsr_reset,
    input  wire logic                 cfg_wr,
    input  wire logic                 cfg_poll_off,
    input  wire logic [7:0]           cfg_data,
    input  wire logic                 spec_wr,
    input  wire logic [7:0]           spec_data,
    input  wire logic                 pd_req,
    input  wire logic                 rd_strobe,
    input  wire frs_pkg::frs_sel_type rd_sel,
    output logic [7:0]                rd_data,
    output logic                      core_reset,
    output logic                      reset_exit,
    output logic                      powerdown,
    output logic                      poll_enable,
    output logic [7:0]                config_value,
    output logic [7:0]                specify_value,
    output logic                      dor_reset_state,
    output logic                      side_select_output,
    output logic [1:0]                drive_number
);

    frs_pkg::frs_state_type q;
    frs_pkg::frs_state_type next_q;
    frs_pkg::frs_st3_type   s3_view;
    logic                   in_reset;
    logic                   idx_edge;
    logic                   is_write;

    assign in_reset = (q.rst_state != frs_pkg::RS_RUN);
    assign idx_edge = q.pins.index_input && !q.idx_prev;
    assign is_write = (cmd_class == frs_pkg::CMD_WRITE)
                   || (cmd_class == frs_pkg::CMD_WRITE_DEL)
                   || (cmd_class == frs_pkg::CMD_FORMAT);

    // Pins are read only after the second synchroniser stage
    assign s3_view = '{
        unused7:           frs_pkg::BIT_ZERO,
        write_protect:     q.pins.write_protect_input,
        one5:              frs_pkg::BIT_ONE,
        track_zero_status: q.pins.track_zero_input,
        one3:              frs_pkg::BIT_ONE,
        side_status:       q.s0.side_status,
        drive_number:      q.s0.drive_number
    };

    always_comb begin
        next_q           = q;
        next_q.pins_meta = pins_raw;
        next_q.pins      = q.pins_meta;
        next_q.idx_prev  = q.pins.index_input;
        next_q.exit      = frs_pkg::BIT_ZERO;

        // Reset sources
        if (q.pins.hw_reset) begin
            next_q.dor_rst = frs_pkg::BIT_ONE;
        end else if (dor_wr) begin
            next_q.dor_rst = !dor_reset_n;
        end
        if (next_q.dor_rst) begin
            next_q.dsr_cnt = '0;
        end else if (dsr_wr && dsr_reset) begin
            next_q.dsr_cnt = frs_pkg::DSR_HOLD;
        end else if (q.dsr_cnt != '0) begin
            next_q.dsr_cnt = q.dsr_cnt - frs_pkg::DSR_ONE;
        end


        case (q.rst_state)
            frs_pkg::RS_RUN: begin
                if (next_q.dor_rst) begin
                    next_q.rst_state = frs_pkg::RS_DOR;
                end else if (next_q.dsr_cnt != '0) begin
                    next_q.rst_state = frs_pkg::RS_DSR;
                end
            end
            frs_pkg::RS_DOR: begin
                if (!next_q.dor_rst) begin
                    next_q.rst_state = frs_pkg::RS_RUN;
                end
            end
            frs_pkg::RS_DSR: begin
                if (next_q.dor_rst) begin
                    next_q.rst_state = frs_pkg::RS_DOR;
                end else if (next_q.dsr_cnt == '0) begin
                    next_q.rst_state = frs_pkg::RS_RUN;
                end
            end
            default: begin
                next_q.rst_state = frs_pkg::RS_DOR;
            end
        endcase

        if (in_reset && next_q.rst_state == frs_pkg::RS_RUN) begin
            next_q.exit = frs_pkg::BIT_ONE;
        end

        // Configuration writes
        if (spec_wr) begin
            next_q.spec = spec_data;
        end

        if (cfg_wr) begin
            next_q.cfg     = cfg_data;
            next_q.poll_en = !cfg_poll_off;
        end

        if (pd_req) begin
            next_q.pd = frs_pkg::BIT_ONE;
        end

        if (in_reset) begin
            // Specify values deliberately survive every reset but power-on
            next_q.pd       = frs_pkg::BIT_ZERO;
            next_q.cfg      = '0;
            next_q.poll_en  = frs_pkg::BIT_ONE;
            next_q.s0       = '0;
            next_q.s1       = '0;
            next_q.s2       = '0;
            next_q.step_cnt = '0;
            next_q.idx_cnt  = '0;
        end else begin

            // New command clears first so a same-cycle event still lands
            if (ev.cmd_start) begin
                next_q.s0       = '0;
                next_q.s1       = '0;
                next_q.s2       = '0;
                next_q.step_cnt = '0;
                next_q.idx_cnt  = '0;
            end

            if (ev.term_valid) begin
                next_q.s0.termination_code = ev.term_code;
            end

            if (ev.pos_end && (cmd_class == frs_pkg::CMD_SEEK
                    || cmd_class == frs_pkg::CMD_REL_SEEK
                    || cmd_class == frs_pkg::CMD_RECAL)) begin
                next_q.s0.positioning_done = frs_pkg::BIT_ONE;
            end

            if (ev.step && cmd_class == frs_pkg::CMD_RECAL
                    && q.step_cnt != frs_pkg::RECAL_LIMIT) begin
                next_q.step_cnt = q.step_cnt + frs_pkg::STEP_ONE;
                if (q.step_cnt + frs_pkg::STEP_ONE == frs_pkg::RECAL_LIMIT
                        && !q.pins.track_zero_input) begin
                    next_q.s0.drive_fault_flag = frs_pkg::BIT_ONE;
                end
            end

            if (ev.rel_under && cmd_class == frs_pkg::CMD_REL_SEEK) begin
                next_q.s0.drive_fault_flag = frs_pkg::BIT_ONE;
            end

            if (ev.sec_over || (ev.xfer_done && !q.pins.transfer_end_input
                    && (cmd_class == frs_pkg::CMD_READ
                    || cmd_class == frs_pkg::CMD_WRITE))) begin
                next_q.s1.end_of_track = frs_pkg::BIT_ONE;
            end

            if (ev.id_crc || ev.data_crc) begin
                next_q.s1.crc_fault = frs_pkg::BIT_ONE;
            end

            if (ev.data_crc) begin
                next_q.s2.data_crc_fault = frs_pkg::BIT_ONE;
            end

            if (ev.late) begin
                next_q.s1.service_late = frs_pkg::BIT_ONE;
            end

            if ((ev.not_found && (cmd_class == frs_pkg::CMD_READ
                    || cmd_class == frs_pkg::CMD_READ_DEL))
                    || (ev.id_fail && cmd_class == frs_pkg::CMD_READ_ID)
                    || (ev.seq_fail && cmd_class == frs_pkg::CMD_READ_TRACK)) begin
                next_q.s1.sector_absent = frs_pkg::BIT_ONE;
            end

            if (is_write && q.pins.write_protect_input) begin
                next_q.s1.write_blocked = frs_pkg::BIT_ONE;
            end

            // Index pulses counted only while hunting an ID mark
            if (ev.id_found) begin
                next_q.idx_cnt = '0;
            end else if (ev.id_search && idx_edge
                    && q.idx_cnt != frs_pkg::IDX_LIMIT) begin
                next_q.idx_cnt = q.idx_cnt + frs_pkg::IDX_ONE;
                if (q.idx_cnt + frs_pkg::IDX_ONE == frs_pkg::IDX_LIMIT) begin
                    next_q.s1.id_sync_missing = frs_pkg::BIT_ONE;
                end
            end

            if (ev.mark_missing) begin
                next_q.s1.id_sync_missing   = frs_pkg::BIT_ONE;
                next_q.s2.data_sync_missing = frs_pkg::BIT_ONE;
            end

            if (ev.mark_seen && ((cmd_class == frs_pkg::CMD_READ
                    && ev.mark_deleted) || (cmd_class == frs_pkg::CMD_READ_DEL
                    && !ev.mark_deleted))) begin
                next_q.s2.control_mark = frs_pkg::BIT_ONE;
            end

            if (ev.id_valid && ev.id_track != cur_track) begin
                next_q.s2.wrong_cylinder = frs_pkg::BIT_ONE;
                if (ev.id_track == frs_pkg::BAD_TRACK) begin
                    next_q.s2.bad_cylinder = frs_pkg::BIT_ONE;
                end
            end
        end

        next_q.s0.side_status  = cur_head;
        next_q.s0.drive_number = cur_drive;

        // Result byte capture
        if (rd_strobe) begin
            case (rd_sel)
                frs_pkg::SEL_ST0: next_q.rdata = q.s0;
                frs_pkg::SEL_ST1: next_q.rdata = q.s1;
                frs_pkg::SEL_ST2: next_q.rdata = q.s2;
                default:          next_q.rdata = s3_view;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            q <= frs_pkg::ST_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign rd_data            = q.rdata;
    assign core_reset         = in_reset;
    assign reset_exit         = q.exit;
    assign powerdown          = q.pd;
    assign poll_enable        = q.poll_en;
    assign config_value       = q.cfg;
    assign specify_value      = q.spec;
    assign dor_reset_state    = q.dor_rst;
    assign side_select_output = q.s0.side_status;
    assign drive_number       = q.s0.drive_number;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    AST_HW_SETS_DOR: assert property (q.pins.hw_reset |=> q.dor_rst && core_reset)
        else $error("pin reset did not set drive output reset");

    AST_DOR_WINS: assert property (q.dor_rst |-> q.rst_state == frs_pkg::RS_DOR)
        else $error("drive output reset not in control");

    AST_DSR_SELF: assert property (
        (q.rst_state == frs_pkg::RS_DSR && !dsr_wr && !dor_wr && !q.pins.hw_reset)
            [*4] |=> !core_reset)
        else $error("data rate reset did not clear itself");

    AST_ABORT: assert property (core_reset |=> q.s1 == '0 && q.s2 == '0)
        else $error("flags survived a reset");

    AST_PD_EXIT: assert property (core_reset |=> !powerdown)
        else $error("powerdown survived a reset");

    AST_POLL: assert property (reset_exit |-> poll_enable && config_value == '0)
        else $error("reset exit without polling");

    AST_SPEC: assert property (core_reset && !spec_wr |=> $stable(specify_value))
        else $error("specify value lost in reset");

    AST_RECAL: assert property (
        ev.step && cmd_class == frs_pkg::CMD_RECAL && !core_reset
            && !q.pins.track_zero_input
            && q.step_cnt == frs_pkg::RECAL_LIMIT - frs_pkg::STEP_ONE
        |=> q.s0.drive_fault_flag)
        else $error("missed recalibrate fault");

    AST_WRONG: assert property (
        ev.id_valid && ev.id_track == frs_pkg::BAD_TRACK && !core_reset
            && cur_track != frs_pkg::BAD_TRACK
        |=> q.s2.wrong_cylinder && q.s2.bad_cylinder)
        else $error("bad track not flagged");

    AST_ST3: assert property (
        rd_strobe && rd_sel == frs_pkg::SEL_ST3 |=> rd_data[5] && rd_data[3] && !rd_data[7])
        else $error("status 3 fixed bits wrong");

    AST_UNUSED: assert property (
        rd_strobe && rd_sel == frs_pkg::SEL_ST2 |=> !rd_data[7] && rd_data[3:2] == '0)
        else $error("status 2 unused bits set");

    AST_TERM: assert property (
        ev.term_valid && !core_reset |=> q.s0.termination_code == $past(ev.term_code))
        else $error("termination code lost");

    AST_SEEK_END: assert property (
        ev.pos_end && cmd_class == frs_pkg::CMD_SEEK && !core_reset |=> q.s0.positioning_done)
        else $error("seek end not flagged");

    AST_REL_UNDER: assert property (
        ev.rel_under && cmd_class == frs_pkg::CMD_REL_SEEK && !core_reset
        |=> q.s0.drive_fault_flag)
        else $error("outward seek not flagged");

    AST_HEAD: assert property (
        frs_pkg::BIT_ONE |=> side_select_output == $past(cur_head)
            && drive_number == $past(cur_drive))
        else $error("head or drive not tracked");

    AST_EOT: assert property (ev.sec_over && !core_reset |=> q.s1.end_of_track)
        else $error("end of track not flagged");

    AST_CRC: assert property (
        ev.data_crc && !core_reset |=> q.s1.crc_fault && q.s2.data_crc_fault)
        else $error("data crc not flagged");

    AST_LATE: assert property (ev.late && !core_reset |=> q.s1.service_late)
        else $error("late service not flagged");

    AST_NO_DATA: assert property (
        ev.not_found && cmd_class == frs_pkg::CMD_READ && !core_reset
        |=> q.s1.sector_absent)
        else $error("missing sector not flagged");

    AST_WP: assert property (
        is_write && q.pins.write_protect_input && !core_reset |=> q.s1.write_blocked)
        else $error("write protect not flagged");

    AST_MISSING: assert property (
        ev.mark_missing && !core_reset |=> q.s1.id_sync_missing && q.s2.data_sync_missing)
        else $error("missing mark not flagged");

endmodule

// >>> verif/frs_drive_model.sv
// Drive cable side: level pins plus a pulsed index line
module frs_drive_model (
    input  wire logic            core_clk,
    input  wire logic [2:0]      lvl,
    input  wire logic            hw,
    output frs_pkg::frs_pins_type pins
);
    timeunit 1ns;
    timeprecision 100ps;

    logic idx;

    initial idx = 1'b0;

    // Index stays low between pulses; edges land off the clock on purpose
    task automatic index_pulse();
        @(posedge core_clk);
        #1 idx = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 idx = 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    // lvl is {transfer end, write protect, track zero}
    assign pins = {lvl[2], lvl[0], lvl[1], idx, hw};
endmodule

// >>> verif/frs_result_status_tb_top.sv
module frs_result_status_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        frs_pkg::frs_ev_type  e;
        frs_pkg::frs_cmd_type c;
        frs_pkg::frs_sel_type s;
        logic [2:0]           p;
        logic [7:0]           x;
    } frs_row_type;

    logic core_clk, srst, dor_wr, dor_reset_n, dsr_wr, dsr_reset, cfg_wr, cfg_poll_off;
    logic cur_head, spec_wr, pd_req, rd_strobe, core_reset, reset_exit, powerdown;
    logic poll_enable, dor_reset_state, side_select_output, hw, ex;
    logic [7:0] cur_track, cfg_data, spec_data, rd_data, config_value, specify_value;
    logic [1:0] cur_drive, drive_number;
    logic [2:0] lvl;
    frs_pkg::frs_ev_type   ev, e, cs;
    frs_pkg::frs_cmd_type  cmd_class;
    frs_pkg::frs_sel_type  rd_sel;
    frs_pkg::frs_pins_type pins_raw;
    frs_row_type           rows[$];
    int                    num_errors, num_checks, n;

    frs_result_status uut (
        .core_clk(core_clk), .srst(srst), .ev(ev), .cmd_class(cmd_class),
        .cur_track(cur_track), .cur_head(cur_head), .cur_drive(cur_drive),
        .pins_raw(pins_raw), .dor_wr(dor_wr), .dor_reset_n(dor_reset_n),
        .dsr_wr(dsr_wr), .dsr_reset(dsr_reset), .cfg_wr(cfg_wr),
        .cfg_poll_off(cfg_poll_off), .cfg_data(cfg_data), .spec_wr(spec_wr),
        .spec_data(spec_data), .pd_req(pd_req), .rd_strobe(rd_strobe), .rd_sel(rd_sel),
        .rd_data(rd_data), .core_reset(core_reset), .reset_exit(reset_exit),
        .powerdown(powerdown), .poll_enable(poll_enable), .config_value(config_value),
        .specify_value(specify_value), .dor_reset_state(dor_reset_state),
        .side_select_output(side_select_output), .drive_number(drive_number)
    );

    frs_drive_model drv (.core_clk(core_clk), .lvl(lvl), .hw(hw), .pins(pins_raw));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic pev(input frs_pkg::frs_ev_type pe);
        ev = pe;
        tick(1);
        ev = '0;
        tick(1);
    endtask

    task automatic rd_chk(input string nm, input frs_pkg::frs_sel_type s, input logic [7:0] x);
        rd_sel = s;
        rd_strobe = 1'b1;
        tick(1);
        rd_strobe = 1'b0;
        chk(nm, rd_data, x);
        tick(1);
    endtask

    task automatic add(input frs_pkg::frs_ev_type ae, input frs_pkg::frs_cmd_type ac,
                       input frs_pkg::frs_sel_type asl, input logic [2:0] ap,
                       input logic [7:0] ax);
        rows.push_back('{ae, ac, asl, ap, ax});
    endtask

    // Host side of the handshake: the active-low reset bit is written high to leave reset
    task automatic release_dor();
        dor_reset_n = 1'b1;
        dor_wr = 1'b1;
        tick(1);
        dor_wr = 1'b0;
        n = 0;
        while (core_reset !== 1'b0 && n < 20) begin
            tick(1);
            n++;
        end
        chk("exit_pulse", 8'(reset_exit), 8'h01);
        chk("dor_clear", 8'(dor_reset_state), 8'h00);
        tick(1);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end

    initial begin
        srst = 1'b1;
        {dor_wr, dor_reset_n, dsr_wr, dsr_reset, cfg_wr, cfg_poll_off} = '0;
        {spec_wr, pd_req, rd_strobe, hw} = '0;
        cur_track = 8'h07;
        cur_head = 1'b1;
        cur_drive = 2'h2;
        cfg_data = 8'hA5;
        spec_data = 8'h5A;
        lvl = 3'h0;
        ev = '0;
        cmd_class = frs_pkg::CMD_NONE;
        rd_sel = frs_pkg::SEL_ST0;
        num_errors = 0;
        num_checks = 0;
        cs = '0;
        cs.cmd_start = 1'b1;
        for (int i = 0; i < 4; i++) begin
            e = '0;
            e.term_valid = 1'b1;
            e.term_code = frs_pkg::frs_term_type'(i);
            add(e, frs_pkg::CMD_NONE, frs_pkg::SEL_ST0, 3'h0, {i[1:0], 6'h06});
        end
        e = '0; e.pos_end = 1'b1; add(e, frs_pkg::CMD_SEEK, frs_pkg::SEL_ST0, 3'h0, 8'h26);
        e = '0; e.rel_under = 1'b1;
        add(e, frs_pkg::CMD_REL_SEEK, frs_pkg::SEL_ST0, 3'h0, 8'h16);
        e = '0; e.sec_over = 1'b1; add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST1, 3'h0, 8'h80);
        e = '0; e.xfer_done = 1'b1; add(e, frs_pkg::CMD_WRITE, frs_pkg::SEL_ST1, 3'h0, 8'h80);
        add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST1, 3'h4, 8'h00);
        e = '0; e.id_crc = 1'b1; add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST1, 3'h0, 8'h20);
        add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST2, 3'h0, 8'h00);
        e = '0; e.data_crc = 1'b1; add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST1, 3'h0, 8'h20);
        add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST2, 3'h0, 8'h20);
        e = '0; e.late = 1'b1; add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST1, 3'h0, 8'h10);
        e = '0; e.not_found = 1'b1; add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST1, 3'h0, 8'h04);
        e = '0; e.id_fail = 1'b1; add(e, frs_pkg::CMD_READ_ID, frs_pkg::SEL_ST1, 3'h0, 8'h04);
        e = '0; e.seq_fail = 1'b1;
        add(e, frs_pkg::CMD_READ_TRACK, frs_pkg::SEL_ST1, 3'h0, 8'h04);
        e = '0;
        add(e, frs_pkg::CMD_WRITE, frs_pkg::SEL_ST1, 3'h2, 8'h02);
        add(e, frs_pkg::CMD_WRITE_DEL, frs_pkg::SEL_ST1, 3'h2, 8'h02);
        add(e, frs_pkg::CMD_FORMAT, frs_pkg::SEL_ST1, 3'h2, 8'h02);
        add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST1, 3'h2, 8'h00);
        add(e, frs_pkg::CMD_NONE, frs_pkg::SEL_ST3, 3'h1, 8'h3E);
        add(e, frs_pkg::CMD_NONE, frs_pkg::SEL_ST3, 3'h2, 8'h6E);
        add(e, frs_pkg::CMD_NONE, frs_pkg::SEL_ST3, 3'h0, 8'h2E);
        e.mark_missing = 1'b1; add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST1, 3'h0, 8'h01);
        add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST2, 3'h0, 8'h01);
        e = '0; e.mark_seen = 1'b1; e.mark_deleted = 1'b1;
        add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST2, 3'h0, 8'h40);
        add(e, frs_pkg::CMD_READ_DEL, frs_pkg::SEL_ST2, 3'h0, 8'h00);
        e.mark_deleted = 1'b0;
        add(e, frs_pkg::CMD_READ_DEL, frs_pkg::SEL_ST2, 3'h0, 8'h40);
        add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST2, 3'h0, 8'h00);
        e = '0; e.id_valid = 1'b1; e.id_track = 8'h05;
        add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST2, 3'h0, 8'h10);
        e.id_track = 8'hFF; add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST2, 3'h0, 8'h12);
        e.id_track = 8'h07; add(e, frs_pkg::CMD_READ, frs_pkg::SEL_ST2, 3'h0, 8'h00);

        repeat (10) @(posedge core_clk);
        #1 srst = 1'b0;
        tick(1);
        chk("core_reset", 8'(core_reset), 8'h01);
        chk("dor_bit", 8'(dor_reset_state), 8'h01);
        chk("poll", 8'(poll_enable), 8'h01);
        chk("spec", specify_value, 8'h00);
        chk("rd_data", rd_data, 8'h00);
        e = '0; e.late = 1'b1; pev(e);
        rd_chk("st1_in_reset", frs_pkg::SEL_ST1, 8'h00);
        release_dor();

        // Pins need two cycles to clear the synchroniser; each command waits three
        foreach (rows[i]) begin
            cmd_class = rows[i].c;
            lvl = rows[i].p;
            tick(3);
            pev(cs);
            pev(rows[i].e);
            rd_chk($sformatf("row%0d", i), rows[i].s, rows[i].x);
        end
        chk("head_pin", 8'(side_select_output), 8'h01);
        chk("drive_pins", 8'(drive_number), 8'h02);
        cur_head = 1'b0;
        cur_drive = 2'h1;
        tick(2);
        chk("head_low", 8'(side_select_output), 8'h00);
        rd_chk("st0_head", frs_pkg::SEL_ST0, 8'h01);
        rd_chk("st3_head", frs_pkg::SEL_ST3, 8'h29);
        cur_head = 1'b1;
        cur_drive = 2'h2;

        cmd_class = frs_pkg::CMD_RECAL;
        lvl = 3'h0;
        tick(3);
        pev(cs);
        e = '0; e.step = 1'b1;
        repeat (79) pev(e);
        rd_chk("recal79", frs_pkg::SEL_ST0, 8'h06);
        pev(e);
        rd_chk("recal80", frs_pkg::SEL_ST0, 8'h16);

        cmd_class = frs_pkg::CMD_READ_ID;
        pev(cs);
        e = '0; e.id_search = 1'b1; ev = e;
        drv.index_pulse();
        tick(4);
        rd_chk("idx1", frs_pkg::SEL_ST1, 8'h00);
        drv.index_pulse();
        tick(4);
        rd_chk("idx2", frs_pkg::SEL_ST1, 8'h01);
        ev = '0;
        tick(1);

        {cfg_poll_off, cfg_wr, spec_wr, pd_req} = 4'hF;
        tick(1);
        {cfg_wr, spec_wr, pd_req} = 3'h0;
        tick(1);
        chk("cfg", config_value, 8'hA5);
        chk("poll_off", 8'(poll_enable), 8'h00);
        chk("pd_on", 8'(powerdown), 8'h01);
        e = '0; e.late = 1'b1; pev(e);
        dsr_reset = 1'b1;
        dsr_wr = 1'b1;
        tick(1);
        dsr_wr = 1'b0;
        n = 0;
        ex = 1'b0;
        repeat (12) begin
            if (core_reset === 1'b1) n++;
            ex |= reset_exit;
            tick(1);
        end
        chk("dsr_len", 8'(n), 8'h04);
        chk("dsr_exit", 8'(ex), 8'h01);
        chk("dsr_pd", 8'(powerdown), 8'h00);
        chk("dsr_cfg", config_value, 8'h00);
        chk("dsr_poll", 8'(poll_enable), 8'h01);
        chk("dsr_spec", specify_value, 8'h5A);
        chk("dsr_dor", 8'(dor_reset_state), 8'h00);
        rd_chk("dsr_st1", frs_pkg::SEL_ST1, 8'h00);

        pd_req = 1'b1;
        tick(1);
        pd_req = 1'b0;
        hw = 1'b1;
        tick(4);
        hw = 1'b0;
        tick(4);
        chk("hw_core", 8'(core_reset), 8'h01);
        chk("hw_dor", 8'(dor_reset_state), 8'h01);
        chk("hw_pd", 8'(powerdown), 8'h00);
        chk("hw_spec", specify_value, 8'h5A);
        dsr_wr = 1'b1;
        tick(1);
        dsr_wr = 1'b0;
        tick(8);
        chk("dor_wins", 8'(core_reset), 8'h01);
        release_dor();

        dor_reset_n = 1'b0;
        dor_wr = 1'b1;
        tick(1);
        dor_wr = 1'b0;
        tick(10);
        chk("dor_hold", 8'(core_reset), 8'h01);
        release_dor();
        print_verdict();
    end
endmodule
